// ===== rtl/pc_pkg.sv
`default_nettype none

package pc_pkg;

    // Word-address layout of one channel.
    localparam int          ADDR_W          = 24;
    localparam int          LOCAL_W         = 17;
    localparam int          CHAN_W          = ADDR_W - LOCAL_W;
    localparam logic [23:0] CHAN_STRIDE     = 24'h020000;
    localparam logic [16:0] CLIENT_BASE     = 17'h01000;

    // Local word offsets inside a channel.
    localparam logic [16:0] OFS_SCRATCH     = 17'h01000;
    localparam logic [16:0] OFS_IDENT       = 17'h01001;
    localparam logic [16:0] OFS_PKT_SIZE    = 17'h01008;
    localparam logic [16:0] OFS_PKT_COUNT   = 17'h01009;
    localparam logic [16:0] OFS_TX_CTRL     = 17'h01010;
    localparam logic [16:0] OFS_SOFT_RESET  = 17'h00310;
    localparam logic [16:0] OFS_MII_RUN     = 17'h01100;
    localparam logic [16:0] OFS_MII_STATUS  = 17'h01102;

    // Reset values.
    localparam logic [31:0] RST_SCRATCH     = 32'h00000000;
    localparam logic [29:0] RST_PKT_SIZE    = 30'h25800040;
    localparam logic [31:0] RST_PKT_COUNT   = 32'h0000000A;
    localparam logic [7:0]  RST_TX_CTRL     = 8'h06;
    localparam logic [2:0]  RST_SOFT_RESET  = 3'h0;

    // Identification word; the value is arbitrary.
    localparam logic [31:0] IDENT_WORD      = 32'h50434C49;

    // Field positions.
    localparam int          SIZE_LO_LSB     = 0;
    localparam int          SIZE_LO_MSB     = 13;
    localparam int          SIZE_HI_LSB     = 16;
    localparam int          SIZE_HI_MSB     = 29;
    localparam int          CTRL_GEN_OFF    = 1;
    localparam int          CTRL_LOOPBACK   = 3;
    localparam int          MII_RUN_BIT     = 0;
    localparam int          MII_PASS_BIT    = 1;
    localparam int          SOFT_RESET_W    = 3;

    // Datapath modes of the core; Gray codes along the usual order.
    typedef enum logic [2:0] {
        MODE_MAC_PCS  = 3'h0,
        MODE_CUSTOM   = 3'h1,
        MODE_OTN      = 3'h3,
        MODE_FLEXE    = 3'h2,
        MODE_PCS_ONLY = 3'h6
    } pc_mode_e;

endpackage : pc_pkg

`default_nettype wire

// ===== rtl/pc_client_csr.sv
`default_nettype none

// Notes on behaviour
// [RL1] Scratch word stores and returns any value.
// [RL2] Read-only identification word, fixed ASCII string.
// [RL3] Size low field; register resets 0x25800040.
// [RL4] Size bits 29:16 give incremental upper limit.
// [RL5] Packet count register resets to ten.
// [RL6] Control bit 1 disables generator; resets 0x6.
// [RL7] Control bit 3 reads MAC loopback state.
// [RL8] Host supplies register clock, 100-161.13 MHz; the bench clock runs at 200 MHz.
// [RL9] Board reset drives core hard reset directly.
// [RL10] Channel spaces stride 0x020000; client at 0x1000.
// [RL11] Host steps soft reset one bit each.
// [RL12] Generator runs on 1, halts on 0.
// [RL13] Status bit 1 reports checker pass, read-only.
// [RL14] Run honoured only in non-MAC modes; resets stopped.
// [RL15] Reads have no side effects; reserved bits kept.
module pc_client_csr #(
    parameter logic [6:0] P_CHANNEL = 7'h00
) (
    // Clock and reset
    input  wire logic                         i_sys_clk,
    input  wire logic                         i_srst,
    // Board reset
    input  wire logic                         i_board_reset_n,
    output logic                              o_core_hard_reset_n,
    // Word-addressed register access
    input  wire logic [pc_pkg::ADDR_W-1:0]    i_csr_addr,
    input  wire logic                         i_csr_write,
    input  wire logic                         i_csr_read,
    input  wire logic [31:0]                  i_csr_wdata,
    output logic [31:0]                       o_csr_rdata,
    output logic                              o_csr_rdvalid,
    // Core status
    input  wire logic [2:0]                   i_core_mode,
    input  wire logic                         i_mac_loopback,
    input  wire logic                         i_mii_checker_pass,
    // Generator settings
    output logic [13:0]                       o_pkt_size,
    output logic [13:0]                       o_pkt_size_limit,
    output logic [31:0]                       o_pkt_count,
    output logic                              o_pktgen_disable,
    output logic [7:0]                        o_tx_ctrl,
    output logic                              o_mii_generator_run,
    output logic [pc_pkg::SOFT_RESET_W-1:0]   o_soft_reset
);

    logic [31:0]                       scratch_q, scratch_d;
    logic [29:0]                       size_q, size_d;
    logic [31:0]                       count_q, count_d;
    logic [7:0]                        ctrl_q, ctrl_d;
    logic                              run_q, run_d;
    logic [pc_pkg::SOFT_RESET_W-1:0]   srst_q, srst_d;
    logic [31:0]                       rdata_q, rdata_d;
    logic                              rdvalid_q;

    // The board reset is passed straight through so the core resets even without a clock.
    assign o_core_hard_reset_n = i_board_reset_n; // [RL9]

    // Channel select and local offset.
    wire [pc_pkg::CHAN_W-1:0]  chan      = i_csr_addr[pc_pkg::ADDR_W-1:pc_pkg::LOCAL_W];
    wire [pc_pkg::LOCAL_W-1:0] local_ofs = i_csr_addr[pc_pkg::LOCAL_W-1:0];
    wire                       chan_hit  = (chan == P_CHANNEL); // [RL10]

    wire hit_scratch = chan_hit && (local_ofs == pc_pkg::OFS_SCRATCH);
    wire hit_ident   = chan_hit && (local_ofs == pc_pkg::OFS_IDENT);
    wire hit_size    = chan_hit && (local_ofs == pc_pkg::OFS_PKT_SIZE);
    wire hit_count   = chan_hit && (local_ofs == pc_pkg::OFS_PKT_COUNT);
    wire hit_ctrl    = chan_hit && (local_ofs == pc_pkg::OFS_TX_CTRL);
    wire hit_srst    = chan_hit && (local_ofs == pc_pkg::OFS_SOFT_RESET);
    wire hit_run     = chan_hit && (local_ofs == pc_pkg::OFS_MII_RUN);
    wire hit_status  = chan_hit && (local_ofs == pc_pkg::OFS_MII_STATUS);

    // The MAC datapath owns its own traffic, so the interface generator only runs without it.
    wire mode_ok = (i_core_mode == pc_pkg::MODE_CUSTOM)   ||
                   (i_core_mode == pc_pkg::MODE_OTN)      ||
                   (i_core_mode == pc_pkg::MODE_FLEXE)    ||
                   (i_core_mode == pc_pkg::MODE_PCS_ONLY); // [RL14]

    // Write side.
    assign scratch_d = (i_csr_write && hit_scratch) ? i_csr_wdata : scratch_q; // [RL1]
    assign size_d    = (i_csr_write && hit_size) ? i_csr_wdata[29:0] : size_q; // [RL3] [RL4]
    assign count_d   = (i_csr_write && hit_count) ? i_csr_wdata : count_q; // [RL5]
    // Reserved control bits keep whatever was last written.
    assign ctrl_d    = (i_csr_write && hit_ctrl) ? i_csr_wdata[7:0] : ctrl_q; // [RL6] [RL15]
    assign srst_d    = (i_csr_write && hit_srst) ? i_csr_wdata[pc_pkg::SOFT_RESET_W-1:0] : srst_q; // [RL11]
    assign run_d     = !mode_ok ? 1'b0 :
                       (i_csr_write && hit_run) ? i_csr_wdata[pc_pkg::MII_RUN_BIT] : run_q; // [RL12] [RL14]

    // Control readback shows live loopback state in bit 3 instead of the stored bit.
    wire [7:0] ctrl_rd = {ctrl_q[7:4], i_mac_loopback, ctrl_q[2:0]}; // [RL7]

    // Read mux; unmapped words read as zero and no read changes any state.
    always_comb begin
        rdata_d = 32'h00000000;
        if (hit_scratch) begin
            rdata_d = scratch_q;
        end else if (hit_ident) begin
            rdata_d = pc_pkg::IDENT_WORD; // [RL2]
        end else if (hit_size) begin
            rdata_d = {2'h0, size_q};
        end else if (hit_count) begin
            rdata_d = count_q;
        end else if (hit_ctrl) begin
            rdata_d = {24'h000000, ctrl_rd};
        end else if (hit_srst) begin
            rdata_d = {29'h00000000, srst_q};
        end else if (hit_run) begin
            rdata_d = {31'h00000000, run_q};
        end else if (hit_status) begin
            rdata_d = {30'h00000000, i_mii_checker_pass, 1'b0}; // [RL13]
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            scratch_q <= pc_pkg::RST_SCRATCH;
            size_q    <= pc_pkg::RST_PKT_SIZE; // [RL3]
            count_q   <= pc_pkg::RST_PKT_COUNT; // [RL5]
            ctrl_q    <= pc_pkg::RST_TX_CTRL; // [RL6]
            srst_q    <= pc_pkg::RST_SOFT_RESET;
            run_q     <= 1'b0; // [RL14]
        end else begin
            scratch_q <= scratch_d;
            size_q    <= size_d;
            count_q   <= count_d;
            ctrl_q    <= ctrl_d;
            srst_q    <= srst_d;
            run_q     <= run_d;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rdata_q   <= 32'h00000000;
            rdvalid_q <= 1'b0;
        end else begin
            rdata_q   <= i_csr_read ? rdata_d : rdata_q; // [RL15]
            rdvalid_q <= i_csr_read;
        end
    end

    assign o_csr_rdata         = rdata_q;
    assign o_csr_rdvalid       = rdvalid_q;
    assign o_pkt_size          = size_q[pc_pkg::SIZE_LO_MSB:pc_pkg::SIZE_LO_LSB]; // [RL3]
    assign o_pkt_size_limit    = size_q[pc_pkg::SIZE_HI_MSB:pc_pkg::SIZE_HI_LSB]; // [RL4]
    assign o_pkt_count         = count_q;
    assign o_pktgen_disable    = ctrl_q[pc_pkg::CTRL_GEN_OFF]; // [RL6]
    assign o_tx_ctrl           = ctrl_q;
    assign o_mii_generator_run = run_q; // [RL12]
    assign o_soft_reset        = srst_q;

endmodule : pc_client_csr

`default_nettype wire

// ===== bench/pc_client_csr_monitor.sv
`default_nettype none
module pc_client_csr_monitor #(parameter logic [6:0] P_CHANNEL = 7'h00) (
    input wire logic                      i_sys_clk, i_srst, i_board_reset_n, o_core_hard_reset_n,
    input wire logic [pc_pkg::ADDR_W-1:0] i_csr_addr,
    input wire logic                      i_csr_write, i_csr_read, o_csr_rdvalid,
    input wire logic [31:0]               i_csr_wdata, o_csr_rdata, o_pkt_count,
    input wire logic [2:0]                i_core_mode,
    input wire logic [7:0]                o_tx_ctrl,
    input wire logic                      o_pktgen_disable, o_mii_generator_run
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic mine = i_csr_addr[23:17] == P_CHANNEL;
    wire logic [16:0] ofs = i_csr_addr[16:0];
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    a_read_answer: assert property (mine && i_csr_read |=> o_csr_rdvalid)
        else $error("read not answered");
    a_no_stray_valid: assert property (!i_csr_read |=> !o_csr_rdvalid)
        else $error("stray read valid");
    a_hard_reset: assert property (o_core_hard_reset_n == i_board_reset_n)
        else $error("hard reset not passed through");
    a_ident_fixed: assert property (mine && i_csr_read && ofs == pc_pkg::OFS_IDENT |=>
        o_csr_rdata == pc_pkg::IDENT_WORD) else $error("ident word wrong");
    a_count_write: assert property (mine && i_csr_write && ofs == pc_pkg::OFS_PKT_COUNT |=>
        o_pkt_count == $past(i_csr_wdata)) else $error("count not written");
    a_foreign_ignored: assert property (!mine && i_csr_write |=> $stable(o_pkt_count) && $stable(o_tx_ctrl))
        else $error("foreign write taken");
    a_disable_bit: assert property (mine && i_csr_write && ofs == pc_pkg::OFS_TX_CTRL |=>
        o_pktgen_disable == $past(i_csr_wdata[1])) else $error("disable bit mismatch");
    a_run_mode: assert property ($rose(o_mii_generator_run) |-> $past(i_core_mode) inside {1, 3, 2, 6})
        else $error("run in wrong mode");
    a_reset_values: assert property (disable iff (1'b0) i_srst |=> o_pkt_count == 32'h0000000A &&
        o_tx_ctrl == 8'h06 && !o_mii_generator_run) else $error("reset values wrong");
endmodule : pc_client_csr_monitor
bind pc_client_csr pc_client_csr_monitor #(.P_CHANNEL(P_CHANNEL)) u_monitor (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_board_reset_n(i_board_reset_n),
    .o_core_hard_reset_n(o_core_hard_reset_n), .i_csr_addr(i_csr_addr), .i_csr_write(i_csr_write),
    .i_csr_read(i_csr_read), .o_csr_rdvalid(o_csr_rdvalid), .i_csr_wdata(i_csr_wdata),
    .o_csr_rdata(o_csr_rdata), .o_pkt_count(o_pkt_count), .i_core_mode(i_core_mode), .o_tx_ctrl(o_tx_ctrl),
    .o_pktgen_disable(o_pktgen_disable), .o_mii_generator_run(o_mii_generator_run)
);
`default_nettype wire

// ===== bench/pc_host_model.sv
`default_nettype none
module pc_host_model (
    input  wire logic        i_sys_clk,
    input  wire logic [31:0] i_rdata,
    input  wire logic        i_rdvalid,
    output logic [23:0]      o_addr,
    output logic             o_write,
    output logic             o_read,
    output logic [31:0]      o_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    int hung = 0;
    initial begin
        {o_addr, o_write, o_read, o_wdata} = '0;
    end
    // Write data is inverted once taken so a late sample never sees a stale match.
    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        @(negedge i_sys_clk);
        {o_addr, o_wdata, o_write} <= {a, d, 1'b1};
        @(negedge i_sys_clk);
        {o_wdata, o_write} <= {~d, 1'b0};
    endtask : wr
    task automatic rd(input logic [23:0] a, output logic [31:0] d);
        int n;
        @(negedge i_sys_clk);
        {o_addr, o_read} <= {a, 1'b1};
        @(negedge i_sys_clk);
        o_read <= 1'b0;
        for (n = 0; n < 4 && i_rdvalid !== 1'b1; n++) @(negedge i_sys_clk);
        if (n == 4) hung++;
        d = i_rdata;
    endtask : rd
endmodule : pc_host_model
`default_nettype wire

// ===== bench/pc_client_csr_tb.sv
`default_nettype none
module pc_client_csr_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, srst = 1, brst_n = 0, lb = 0, pass = 0, w, r, hn, rv, dis, run;
    logic [2:0] mode = 0, sr;
    logic [2:0] sq[6] = '{3'h1, 3'h3, 3'h7, 3'h6, 3'h4, 3'h0};
    logic [23:0] a;
    logic [31:0] wd, rdat, d, v, cnt;
    logic [13:0] sz, lim;
    logic [7:0] ctl;
    int miscompares = 0, tests_run = 0;
    pc_client_csr dut (.i_sys_clk(clk), .i_srst(srst), .i_board_reset_n(brst_n), .o_core_hard_reset_n(hn),
        .i_csr_addr(a), .i_csr_write(w), .i_csr_read(r), .i_csr_wdata(wd), .o_csr_rdata(rdat),
        .o_csr_rdvalid(rv), .i_core_mode(mode), .i_mac_loopback(lb), .i_mii_checker_pass(pass),
        .o_pkt_size(sz), .o_pkt_size_limit(lim), .o_pkt_count(cnt), .o_pktgen_disable(dis),
        .o_tx_ctrl(ctl), .o_mii_generator_run(run), .o_soft_reset(sr));
    pc_host_model h (.i_sys_clk(clk), .i_rdata(rdat), .i_rdvalid(rv), .o_addr(a), .o_write(w), .o_read(r),
        .o_wdata(wd));
    function automatic logic [23:0] ad(input logic [16:0] o);
        return {7'h00, o};
    endfunction : ad
    function automatic logic run_ok(input logic [2:0] m);
        return m inside {3'h1, 3'h3, 3'h2, 3'h6};
    endfunction : run_ok
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            miscompares++;
        end
    endtask : chk
    task automatic summarize();
        miscompares += h.hung;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        #200us;
        miscompares++;
        summarize();
    end
    initial begin
        void'($urandom(32'h22E6));
        repeat (3) @(negedge clk);
        srst = 0;
        h.rd(ad(pc_pkg::OFS_PKT_SIZE), d); chk("size rst", 32'h25800040, d);
        h.rd(ad(pc_pkg::OFS_PKT_COUNT), d); chk("count rst", 32'h0000000A, d);
        h.rd(ad(pc_pkg::OFS_TX_CTRL), d); chk("ctrl rst", 32'h00000006, d);
        h.wr(ad(pc_pkg::OFS_IDENT), 32'hFFFF0000);
        h.rd(ad(pc_pkg::OFS_IDENT), d); chk("ident", pc_pkg::IDENT_WORD, d);
        repeat (8) begin
            v = $urandom;
            {brst_n, pass, lb} = v[31:29];
            h.wr(ad(pc_pkg::OFS_PKT_COUNT), ~v); chk("count out", ~v, cnt);
            h.rd(ad(pc_pkg::OFS_PKT_COUNT), d); chk("count", ~v, d);
            h.wr(ad(pc_pkg::OFS_SCRATCH), v);
            h.wr({7'h01, pc_pkg::OFS_SCRATCH}, ~v);
            h.rd(ad(pc_pkg::OFS_SCRATCH), d); chk("scratch", v, d);
            chk("hard reset", 32'(brst_n), 32'(hn));
            h.wr(ad(pc_pkg::OFS_PKT_SIZE), v); chk("size", {2'h0, v[29:16], 2'h0, v[13:0]}, {2'h0, lim, 2'h0, sz});
            h.rd(ad(pc_pkg::OFS_PKT_SIZE), d); chk("size rd", {2'h0, v[29:0]}, d);
            h.wr(ad(pc_pkg::OFS_TX_CTRL), v); chk("gen off", 32'(v[1]), 32'(dis));
            chk("ctrl out", {24'h0, v[7:0]}, {24'h0, ctl});
            h.rd(ad(pc_pkg::OFS_TX_CTRL), d); chk("ctrl rd", {24'h0, v[7:4], lb, v[2:0]}, d);
        end
        h.rd(ad(17'h01FFF), d); chk("unmapped", 32'h0, d);
        for (int m = 0; m < 8; m++) begin
            mode = m[2:0];
            h.wr(ad(pc_pkg::OFS_MII_RUN), 32'h1); chk("run", 32'(run_ok(mode)), 32'(run));
            h.rd(ad(pc_pkg::OFS_MII_STATUS), d); chk("pass", {30'h0, pass, 1'b0}, d);
            h.wr(ad(pc_pkg::OFS_MII_RUN), 32'h0); chk("stop", 32'h0, 32'(run));
        end
        foreach (sq[i]) begin
            h.wr(ad(pc_pkg::OFS_SOFT_RESET), 32'(sq[i])); chk("soft reset", 32'(sq[i]), 32'(sr));
        end
        summarize();
    end
endmodule : pc_client_csr_tb
`default_nettype wire
